// >>> core/fpm_core.sv
// fault protection manager: deglitch, latch, pwm safe state, power good
`timescale 1ns/1ps
// Function
// [RL1] overvoltage after 1us sets flag, drops good
// [RL2] any fault or enable low drops good; code drops good only on faults whose enable bit is set
// [RL3] hold target 45us, pwm tri-state or low
// [RL4] then ramp target down at 1.5mV/us
// [RL5] pwm state from voltage versus target
// [RL6] overvoltage latched until enable toggle, flag clear
// [RL7] enable bit 0 gates only overvoltage action
// [RL8] undervoltage 3us: tri-state, discharge, flag bit 1
// [RL9] undervoltage fraction from 2-bit field, default 0.4
// [RL10] undervoltage latched until enable toggle
// [RL11] enable bit 1 gates only undervoltage action
// [RL12] undervoltage masked until power good first high
// [RL13] die overtemp 45us: tri-state, flag bit 3
// [RL14] die overtemp latched until enable toggle
// [RL15] enable bit 3 gates only overtemp action
// [RL16] thermal sense over level: tri-state, bit 4
// [RL17] thermal sense latched until enable toggle
// [RL18] enable bit 4 gates only thermal action
// [RL19] compare current monitor with 6-bit threshold
// [RL20] current over limit: tri-state, flag bit 2
// [RL21] current fault latched until enable toggle
// [RL22] enable bit 2 gates only current action
// [RL23] deglitch counter restarts when condition absent
module fpm_core (
  input  wire logic       ref_clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       enable_i,
  input  wire logic [7:0] sensed_output_voltage_i,
  input  wire logic [7:0] external_reference_voltage_i,
  input  wire logic [7:0] target_voltage_code_i,
  input  wire logic [7:0] ov_threshold_i,
  input  wire logic [7:0] thermal_sense_voltage_i,
  input  wire logic [7:0] summed_current_monitor_voltage_i,
  input  wire logic [7:0] die_temp_code_i,
  input  wire logic       softstart_done_i,
  input  wire logic       reg_wr_i,
  input  wire logic [7:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  output logic      [7:0] reg_rdata_o,
  output logic            power_good_output_o,
  output logic            pwm_tristate_o,
  output logic            pwm_low_o,
  output logic            discharge_o,
  output logic      [7:0] internal_target_o
);
  import fpm_pkg::*;

  // =====================================================================
  // state
  typedef struct packed {
    logic [2:0]        en_sync;
    logic [1:0]        sv_sync0;
    logic [7:0]        soc_dgl, soc_th, uv_sel, ot_sel, prot_en, ts_dgl;
    logic [4:0]        flags;
    logic [4:0]        act;
    logic [4:0][FPM_CW-1:0] cnt;
    logic              pg, pg_seen;
    fpm_ov_t           ov_st;
    logic [FPM_CW-1:0] ov_cnt;
    logic [7:0]        tgt;
    logic [7:0]        rdata;
  } fpm_state_t;

  fpm_state_t r, next_r;

  // =====================================================================
  // helpers
  function automatic logic [FPM_CW-1:0] sel_dgl(input logic [1:0] c);
    case (c)
      2'd0:    sel_dgl = FPM_CW'(FPM_SEL_DGL_US0 * FPM_CLK_MHZ);
      2'd1:    sel_dgl = FPM_CW'(FPM_SEL_DGL_US1 * FPM_CLK_MHZ);
      2'd2:    sel_dgl = FPM_CW'(FPM_SEL_DGL_US2 * FPM_CLK_MHZ);
      default: sel_dgl = FPM_CW'(FPM_SEL_DGL_US3 * FPM_CLK_MHZ);
    endcase
  endfunction : sel_dgl

  // undervoltage threshold: 0.4/0.5/0.6/0.7 of reference, in tenths
  function automatic logic [7:0] uv_level(input logic [1:0] c,
                                          input logic [7:0] ref_v);
    logic [11:0] p;
    p = 12'(ref_v) * (12'd4 + 12'(c));
    uv_level = 8'(p / 12'd10);
  endfunction : uv_level

  // die temperature code threshold for 150/140/130/120 C
  function automatic logic [7:0] ot_level(input logic [1:0] c);
    ot_level = 8'd150 - {3'd0, c, 3'd0} - {5'd0, c, 1'b0};
  endfunction : ot_level

  logic [4:0]             cond;
  logic [4:0][FPM_CW-1:0] lim;
  logic                   en_s, en_prev, release_now, any_act;

  // =====================================================================
  // next state
  always_comb begin
    next_r = r;
    // two-flop enable sync plus edge history
    next_r.en_sync = {r.en_sync[1:0], enable_i};
    en_s    = r.en_sync[1];
    en_prev = r.en_sync[2];
    release_now = en_s & ~en_prev;             // rising enable releases
    next_r.sv_sync0 = {r.sv_sync0[0], softstart_done_i};

    // raw conditions
    cond[FPM_BIT_OV]  = sensed_output_voltage_i > ov_threshold_i;
    cond[FPM_BIT_UV]  = r.pg_seen &                                 // RL12
      (sensed_output_voltage_i <
       uv_level(r.uv_sel[1:0], external_reference_voltage_i));     // RL9
    cond[FPM_BIT_SOC] = summed_current_monitor_voltage_i >
                        {2'b00, r.soc_th[5:0]} << 2;               // RL19
    cond[FPM_BIT_OT]  = die_temp_code_i > ot_level(r.ot_sel[1:0]);
    cond[FPM_BIT_TS]  = thermal_sense_voltage_i > FPM_TS_SD_CODE;
    lim[FPM_BIT_OV]   = FPM_CW'(FPM_OV_DGL_CYC);
    lim[FPM_BIT_UV]   = FPM_CW'(FPM_UV_DGL_CYC);
    lim[FPM_BIT_SOC]  = sel_dgl(r.soc_dgl[1:0]);                   // RL20
    lim[FPM_BIT_OT]   = FPM_CW'(FPM_OT_DGL_CYC);
    lim[FPM_BIT_TS]   = sel_dgl(r.ts_dgl[1:0]);                    // RL16

    // deglitch counters, flags and latched actions
    for (int i = 0; i < 5; i++) begin
      if (!cond[i])
        next_r.cnt[i] = '0;                                        // RL23
      else if (r.cnt[i] != lim[i])
        next_r.cnt[i] = r.cnt[i] + FPM_CW'(1);
      if (release_now) begin
        next_r.flags[i] = 1'b0;                 // RL6 RL10 RL14 RL17 RL21
        next_r.act[i]   = 1'b0;
      end
      if (cond[i] && r.cnt[i] == lim[i]) begin
        next_r.flags[i] = 1'b1;                 // RL1 RL8 RL13 RL16 RL20
        if (r.prot_en[i])
          next_r.act[i] = 1'b1;                 // RL7 RL11 RL15 RL18 RL22
      end
    end

    // power good: latched high at soft-start end, low on enabled fault or enable low
    any_act = |next_r.act;
    if (!en_s || any_act || (|(next_r.flags & r.prot_en[4:0])))
      next_r.pg = 1'b0;                                            // RL2
    else if (r.sv_sync0[1])
      next_r.pg = 1'b1;
    if (r.pg)
      next_r.pg_seen = 1'b1;
    if (!en_s)
      next_r.pg_seen = 1'b0;

    // overvoltage soft-stop sequencer
    case (r.ov_st)
      FPM_OV_IDLE: begin
        next_r.tgt = target_voltage_code_i;
        if (next_r.act[FPM_BIT_OV]) begin
          next_r.ov_st  = FPM_OV_HOLD;
          next_r.ov_cnt = '0;
        end
      end
      FPM_OV_HOLD: begin                                           // RL3
        if (r.ov_cnt == FPM_CW'(FPM_OV_HOLD_CYC - 1)) begin
          next_r.ov_st  = FPM_OV_RAMP;
          next_r.ov_cnt = '0;
        end else
          next_r.ov_cnt = r.ov_cnt + FPM_CW'(1);
      end
      FPM_OV_RAMP: begin                                           // RL4
        if (r.tgt == 8'h00)
          next_r.ov_st = FPM_OV_DONE;
        else if (r.ov_cnt == FPM_CW'(FPM_RAMP_CYC - 1)) begin
          next_r.tgt    = r.tgt - 8'h01;
          next_r.ov_cnt = '0;
        end else
          next_r.ov_cnt = r.ov_cnt + FPM_CW'(1);
      end
      FPM_OV_DONE: ;
      default: next_r.ov_st = FPM_OV_IDLE;
    endcase
    if (release_now)
      next_r.ov_st = FPM_OV_IDLE;

    // register writes
    if (reg_wr_i) begin
      case (reg_addr_i)
        FPM_SOC_DGL_ADDR: next_r.soc_dgl = reg_wdata_i;
        FPM_SOC_TH_ADDR:  next_r.soc_th  = reg_wdata_i;
        FPM_UV_SEL_ADDR:  next_r.uv_sel  = reg_wdata_i;
        FPM_OT_SEL_ADDR:  next_r.ot_sel  = reg_wdata_i;
        FPM_PROT_EN_ADDR: next_r.prot_en = reg_wdata_i;
        FPM_TS_DGL_ADDR:  next_r.ts_dgl  = reg_wdata_i;
        default:          ;
      endcase
    end

    // registered read data
    case (reg_addr_i)
      FPM_SOC_DGL_ADDR: next_r.rdata = r.soc_dgl;
      FPM_SOC_TH_ADDR:  next_r.rdata = r.soc_th;
      FPM_UV_SEL_ADDR:  next_r.rdata = r.uv_sel;
      FPM_OT_SEL_ADDR:  next_r.rdata = r.ot_sel;
      FPM_PROT_EN_ADDR: next_r.rdata = r.prot_en;
      FPM_STATUS_ADDR:  next_r.rdata = {3'b000, r.flags};
      FPM_TS_DGL_ADDR:  next_r.rdata = r.ts_dgl;
      default:          next_r.rdata = 8'h00;
    endcase
  end

  // =====================================================================
  // state register
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r         <= '0;
      r.soc_dgl <= FPM_SOC_DGL_RST;
      r.soc_th  <= FPM_SOC_TH_RST;
      r.uv_sel  <= FPM_UV_SEL_RST;
      r.ot_sel  <= FPM_OT_SEL_RST;
      r.prot_en <= FPM_PROT_EN_RST;
      r.ts_dgl  <= FPM_TS_DGL_RST;
      r.ov_st   <= FPM_OV_IDLE;
    end else begin
      r <= next_r;
    end
  end

  // =====================================================================
  // outputs
  always_comb begin
    reg_rdata_o         = r.rdata;
    power_good_output_o = r.pg;
    internal_target_o   = r.tgt;
    discharge_o         = r.act[FPM_BIT_UV];                       // RL8
    pwm_tristate_o      = |r.act[4:1];
    pwm_low_o           = 1'b0;
    if (r.ov_st != FPM_OV_IDLE && !(|r.act[4:1])) begin
      // above target: tri-state; at or below: low pulse
      pwm_tristate_o = sensed_output_voltage_i > r.tgt;            // RL5
      pwm_low_o      = !(sensed_output_voltage_i > r.tgt);
    end
  end
endmodule : fpm_core

// >>> pkg/fpm_pkg.sv
// package: fault protection manager constants and types
package fpm_pkg;
  // =====================================================================
  // register offsets
  localparam logic [7:0] FPM_SOC_DGL_ADDR  = 8'h23;
  localparam logic [7:0] FPM_SOC_TH_ADDR   = 8'h24;
  localparam logic [7:0] FPM_UV_SEL_ADDR   = 8'h27;
  localparam logic [7:0] FPM_OT_SEL_ADDR   = 8'h28;
  localparam logic [7:0] FPM_PROT_EN_ADDR  = 8'h29;
  localparam logic [7:0] FPM_STATUS_ADDR   = 8'h2a;
  localparam logic [7:0] FPM_TS_DGL_ADDR   = 8'h33;
  // =====================================================================
  // field positions in enable and status registers
  localparam int FPM_BIT_OV  = 0;
  localparam int FPM_BIT_UV  = 1;
  localparam int FPM_BIT_SOC = 2;
  localparam int FPM_BIT_OT  = 3;
  localparam int FPM_BIT_TS  = 4;
  // =====================================================================
  // reset values
  localparam logic [7:0] FPM_SOC_DGL_RST = 8'h00;
  localparam logic [7:0] FPM_SOC_TH_RST  = 8'h3f;
  localparam logic [7:0] FPM_UV_SEL_RST  = 8'h00; // code 0 -> 0.4 x ref
  localparam logic [7:0] FPM_OT_SEL_RST  = 8'h00; // code 0 -> 150 C
  localparam logic [7:0] FPM_PROT_EN_RST = 8'h1f;
  localparam logic [7:0] FPM_TS_DGL_RST  = 8'h00;
  // =====================================================================
  // timing: clock 50 MHz
  localparam int FPM_CLK_MHZ     = 50;
  localparam int FPM_OV_DGL_US   = 1;
  localparam int FPM_UV_DGL_US   = 3;
  localparam int FPM_OT_DGL_US   = 45;
  localparam int FPM_OV_HOLD_US  = 45;
  localparam int FPM_OV_DGL_CYC  = FPM_OV_DGL_US * FPM_CLK_MHZ;
  localparam int FPM_UV_DGL_CYC  = FPM_UV_DGL_US * FPM_CLK_MHZ;
  localparam int FPM_OT_DGL_CYC  = FPM_OT_DGL_US * FPM_CLK_MHZ;
  localparam int FPM_OV_HOLD_CYC = FPM_OV_HOLD_US * FPM_CLK_MHZ;
  // 2-bit selectable deglitch, in microseconds per code
  localparam int FPM_SEL_DGL_US0 = 1;
  localparam int FPM_SEL_DGL_US1 = 5;
  localparam int FPM_SEL_DGL_US2 = 10;
  localparam int FPM_SEL_DGL_US3 = 20;
  // ramp: target code lsb in mV, slew 1.5 mV/us -> one lsb per step
  localparam int FPM_TGT_LSB_UV  = 1500;  // code lsb in microvolts
  localparam int FPM_SLEW_UV_US  = 1500;  // slew in microvolts per us
  localparam int FPM_RAMP_CYC    =
    (FPM_TGT_LSB_UV * FPM_CLK_MHZ) / FPM_SLEW_UV_US;
  // thermal shutdown level: 0.8 V on an 8-bit scale of full range
  localparam logic [7:0] FPM_TS_SD_CODE = 8'h66;
  localparam int FPM_CW = 12;
  // =====================================================================
  // overvoltage soft-stop states
  typedef enum logic [1:0] {
    FPM_OV_IDLE = 2'b00,
    FPM_OV_HOLD = 2'b01,
    FPM_OV_RAMP = 2'b11,
    FPM_OV_DONE = 2'b10
  } fpm_ov_t;
endpackage : fpm_pkg

// >>> verification/fpm_core_assertions.sv
// checker: protection manager port relations
`timescale 1ns/1ps
module fpm_core_chk (
  input wire logic       ref_clk_i,
  input wire logic       rst_n_i,
  input wire logic       enable_i,
  input wire logic [7:0] sensed_output_voltage_i,
  input wire logic [7:0] ov_threshold_i,
  input wire logic       softstart_done_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic       power_good_output_o,
  input wire logic       pwm_tristate_o,
  input wire logic       discharge_o,
  input wire logic [7:0] internal_target_o
);
  import fpm_pkg::*;
  logic [6:0] ov_cnt;
  logic       mapped;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  // =====================================================================
  // helpers: overvoltage run length, address decode
  assign mapped = reg_addr_i inside {FPM_SOC_DGL_ADDR, FPM_SOC_TH_ADDR,
    FPM_UV_SEL_ADDR, FPM_OT_SEL_ADDR, FPM_PROT_EN_ADDR, FPM_STATUS_ADDR,
    FPM_TS_DGL_ADDR};
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) ov_cnt <= 7'h00;
    else if (sensed_output_voltage_i <= ov_threshold_i) ov_cnt <= 7'h00;
    else if (ov_cnt != 7'h7f) ov_cnt <= ov_cnt + 7'h01;
  end
  // =====================================================================
  // assertions
  a_ov_pg_drop: assert property (ov_cnt == 7'h3c |-> !power_good_output_o)
    else $error("power good high after overvoltage");
  a_en_pg_drop: assert property (!enable_i [*4] |=> !power_good_output_o)
    else $error("power good high with enable low");
  a_pg_rise_cause: assert property ($rose(power_good_output_o) |->
    softstart_done_i && enable_i) else $error("power good rose early");
  a_uv_tristate: assert property (discharge_o |-> pwm_tristate_o)
    else $error("discharge without tristate");
  a_uv_pg_low: assert property (discharge_o |-> !power_good_output_o)
    else $error("discharge with power good high");
  a_rd_unmapped: assert property (!mapped |=> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  a_ramp_step: assert property (ov_cnt > 7'h3c &&
    internal_target_o != $past(internal_target_o) |->
    internal_target_o == $past(internal_target_o) - 8'h01)
    else $error("target step not one lsb down");
  a_ramp_gap: assert property (ov_cnt > 7'h3c &&
    $changed(internal_target_o) |=> $stable(internal_target_o) [*8])
    else $error("target steps too close");
  // main scenarios seen
  c_discharge: cover property ($rose(discharge_o));
  c_ov_seen: cover property (ov_cnt == 7'h3c);
  c_pg_rise: cover property ($rose(power_good_output_o));
endmodule : fpm_core_chk
bind fpm_core fpm_core_chk fpm_core_chk_i (.*);

// >>> verification/fpm_plant.sv
// partner model: output stage seen through the sense input
`timescale 1ns/1ps
module fpm_plant (
  input  wire logic       ref_clk_i,
  input  wire logic       rst_n_i,
  input  wire logic [7:0] level_i,
  input  wire logic       discharge_i,
  output logic      [7:0] vout_o
);
  // follows the set level, sinks one lsb a cycle while discharged, reloads the set level on reaching zero
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) vout_o <= 8'h00;
    else if (discharge_i && vout_o != 8'h00) vout_o <= vout_o - 8'h01;
    else vout_o <= level_i;
  end
endmodule : fpm_plant

// >>> verification/fpm_core_tb_top.sv
// testbench: register map, fault latching and release
`timescale 1ns/1ps
module fpm_core_tb_top;
  import fpm_pkg::*;
  logic       ref_clk_i, pg, tri_s, dis, pwm_lo;
  logic       rst_n_i = 1'b0, en = 1'b0, done = 1'b0;
  logic       wr = 1'b0, rv = 1'b0, rd_d = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, lvl = 8'h64, ovth = 8'hc0;
  logic [7:0] ts = 8'h00, cur = 8'h00, die = 8'h19;
  logic [7:0] vout, rdata, tgt;
  logic [7:0] exp_q[$];
  int         num_errors = 0, check_count = 0, th;
  fpm_plant fpm_plant_i (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .level_i(lvl), .discharge_i(dis), .vout_o(vout));
  fpm_core fpm_core_i (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .enable_i(en), .sensed_output_voltage_i(vout),
    .external_reference_voltage_i(8'h64), .target_voltage_code_i(8'h64),
    .ov_threshold_i(ovth), .thermal_sense_voltage_i(ts),
    .summed_current_monitor_voltage_i(cur), .die_temp_code_i(die),
    .softstart_done_i(done), .reg_wr_i(wr), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_rdata_o(rdata), .power_good_output_o(pg),
    .pwm_tristate_o(tri_s), .pwm_low_o(pwm_lo), .discharge_o(dis),
    .internal_target_o(tgt));
  // =====================================================================
  // clock, read watcher, watchdog
  initial begin
    ref_clk_i = 1'b0;
    forever #10 ref_clk_i = ~ref_clk_i;
  end
  always @(posedge ref_clk_i) rd_d <= rv;
  always @(negedge ref_clk_i) if (rd_d) chk("rdata", rdata, exp_q.pop_front());
  initial begin
    run(20000);
    num_errors++;
    summarize();
  end
  // =====================================================================
  // tasks
  task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
    check_count++;
    if (s !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic run(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask : run
  task automatic wrr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk_i);
    wr <= 1'b0;
  endtask : wrr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk_i);
    addr <= a;
    rv <= 1'b1;
    exp_q.push_back(e);
    @(posedge ref_clk_i);
    rv <= 1'b0;
  endtask : rd
  // drop enable, raise it again, flags must be gone
  task automatic rel();
    en <= 1'b0;
    run(6);
    chk("pg", 8'(pg), 8'h00);
    en <= 1'b1;
    run(12);
    rd(FPM_STATUS_ADDR, 8'h00);
  endtask : rel
  task automatic trip(input logic [7:0] st, input int n);
    run(n);
    chk("tristate", 8'(tri_s), 8'h01);
    chk("pg", 8'(pg), 8'h00);
    rd(FPM_STATUS_ADDR, st);
  endtask : trip
  task automatic summarize();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : summarize
  // =====================================================================
  // main sequence
  initial begin
    void'($urandom(78));
    run(5);
    rst_n_i <= 1'b1;
    rd(FPM_SOC_DGL_ADDR, FPM_SOC_DGL_RST);
    rd(FPM_SOC_TH_ADDR, FPM_SOC_TH_RST);
    rd(FPM_UV_SEL_ADDR, FPM_UV_SEL_RST);
    rd(FPM_OT_SEL_ADDR, FPM_OT_SEL_RST);
    rd(FPM_PROT_EN_ADDR, FPM_PROT_EN_RST);
    rd(FPM_TS_DGL_ADDR, FPM_TS_DGL_RST);
    rd(8'h00, 8'h00);
    wrr(FPM_STATUS_ADDR, 8'hff);
    rd(FPM_STATUS_ADDR, 8'h00);
    en <= 1'b1;
    done <= 1'b1;
    run(10);
    chk("pg", 8'(pg), 8'h01);
    // undervoltage with its action disabled, then enabled at 0.6
    wrr(FPM_PROT_EN_ADDR, 8'h1d);
    lvl <= 8'h20;
    run(200);
    chk("discharge", 8'(dis), 8'h00);
    rd(FPM_STATUS_ADDR, 8'h02);
    lvl <= 8'h64;
    rel();
    wrr(FPM_PROT_EN_ADDR, 8'h1f);
    wrr(FPM_UV_SEL_ADDR, 8'h02);
    lvl <= 8'h30;
    trip(8'h02, 200);
    chk("discharge", 8'(dis), 8'h01);
    lvl <= 8'h64;
    rel();
    // summed current at and above a random limit
    th = $urandom_range(60, 8);
    wrr(FPM_SOC_TH_ADDR, 8'(th));
    rd(FPM_SOC_TH_ADDR, 8'(th));
    cur <= 8'(th * 4);
    run(100);
    rd(FPM_STATUS_ADDR, 8'h00);
    cur <= 8'(th * 4 + 1);
    trip(8'h04, 60);
    cur <= 8'h00;
    rel();
    // thermal sense, interrupted run restarts the deglitch
    wrr(FPM_TS_DGL_ADDR, 8'h01);
    ts <= 8'h67;
    run(200);
    ts <= 8'h66;
    run(1);
    ts <= 8'h67;
    run(200);
    rd(FPM_STATUS_ADDR, 8'h00);
    trip(8'h10, 80);
    ts <= 8'h00;
    rel();
    // die temperature over the 140 setting
    wrr(FPM_OT_SEL_ADDR, 8'h01);
    die <= 8'd141;
    trip(8'h08, 2300);
    die <= 8'h19;
    rel();
    // overvoltage: hold at target, then slow ramp down
    lvl <= 8'hd0;
    run(60);
    chk("pg", 8'(pg), 8'h00);
    rd(FPM_STATUS_ADDR, 8'h01);
    run(2100);
    chk("target", tgt, 8'h64);
    chk("ov_tristate", 8'(tri_s), 8'h01);
    chk("ov_low", 8'(pwm_lo), 8'h00);
    // output below target during soft-stop: low pulses
    lvl <= 8'h50;
    run(3);
    chk("ov_tristate", 8'(tri_s), 8'h00);
    chk("ov_low", 8'(pwm_lo), 8'h01);
    run(300);
    chk("ramp", 8'(tgt < 8'h64 && tgt > 8'h5b), 8'h01);
    lvl <= 8'h64;
    rel();
    run(20);
    summarize();
  end
endmodule : fpm_core_tb_top
